// [common/rqh_if.sv]
// register bus between the receive-queue device and its host
// assumes both ends share aclk; strobes last one cycle
`timescale 1ns/10ps
interface rqh_if (
   input wire logic aclk
);
   logic [7:0] addr;
   logic [15:0] wdata;
   logic wr;
   logic rd;
   logic [15:0] rdata;
   logic ack;
   logic irq;
   modport dev (input addr, wdata, wr, rd, output rdata, ack, irq);
   modport hst (output addr, wdata, wr, rd, input rdata, ack, irq);
endinterface

// [common/rqh_pkg.sv]
// constants shared by the receive-queue device end and the host end
// assumes a 100 MHz aclk and a 16-bit register bus between the ends
package rqh_pkg;
   // ------------------------------------------------------------
   // device register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_C1 = 8'h74;
   localparam logic [7:0] OFS_C2 = 8'h76;
   localparam logic [7:0] OFS_HSR = 8'h7c;
   localparam logic [7:0] OFS_HBC = 8'h7e;
   localparam logic [7:0] OFS_QC = 8'h82;
   localparam logic [7:0] OFS_DP = 8'h86;
   localparam logic [7:0] OFS_DTT = 8'h8c;
   localparam logic [7:0] OFS_DBT = 8'h8e;
   localparam logic [7:0] OFS_IER = 8'h90;
   localparam logic [7:0] OFS_ISR = 8'h92;
   localparam logic [7:0] OFS_FC = 8'h9c;
   localparam logic [7:0] OFS_DATA = 8'hd0;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int C1_EN = 0;
   localparam int C1_FLOW = 10;
   localparam int QC_DMA = 3;
   localparam int QC_ADQ = 4;
   localparam int QC_FCE = 5;
   localparam int QC_BCE = 6;
   localparam int QC_DTE = 7;
   localparam int QC_OFS = 9;
   localparam int QC_FCS = 10;
   localparam int QC_BCS = 11;
   localparam int QC_DTS = 12;
   localparam int DP_AINC = 14;
   localparam int IS_RX = 13;
   localparam logic [15:0] QC_WMASK = 16'h02f8;
   localparam logic [15:0] RST_REG = 16'h0000;
   // ------------------------------------------------------------
   // timing and sizes
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS = 1;
   localparam int US_CYC = (US_NS * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MAX_BYTES = 2000;
   localparam int MAX_FRM_WORDS = 2 + ((MAX_BYTES + 2 + 3) / 4) * 2;
   // ------------------------------------------------------------
   // host end: axi4-lite registers and bus ops
   // ------------------------------------------------------------
   localparam logic [7:0] H_CMD = 8'h00;
   localparam logic [7:0] H_STAT = 8'h04;
   localparam logic [7:0] H_DATA = 8'h08;
   localparam logic [1:0] OP_WR = 2'h0;
   localparam logic [1:0] OP_RD = 2'h1;
   localparam logic [1:0] OP_FRM = 2'h2;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// [dv/rqh_monitor.sv]
// assertions on the register bus between device and host ends
// assumes it sits beside the interface and shares its aclk
`timescale 1ns/10ps
module rqh_monitor
   import rqh_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic ack,
   input wire logic irq
);
   // ---------------------------------------------
   // shadow of writes; arm marks a fresh window
   // ---------------------------------------------
   logic [15:0] mir_r [256];
   logic arm_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mir_r <= '{default: RST_REG};
         arm_r <= 1'b0;
      end else begin
         if (wr)
            mir_r[addr] <= wdata;
         // rewrite of an open window does not re-arm
         if (wr && addr == OFS_QC)
            arm_r <= wdata[QC_DMA] && !mir_r[OFS_QC][QC_DMA];
         else if (rd && addr == OFS_DATA)
            arm_r <= 1'b0;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_ack; (wr || rd) |=> ack ##1 !ack; endproperty
   a_ack: assert property (p_ack) else $error("bus answer");
   property p_dummy;
      rd && addr == OFS_DATA && arm_r |=> rdata == 16'h0000;
   endproperty
   a_dummy: assert property (p_dummy) else $error("dummy read");
   property p_gate;
      wr && addr == OFS_IER && !wdata[IS_RX] |=> !irq;
   endproperty
   a_gate: assert property (p_gate) else $error("irq mask");
   property p_c1;
      rd && addr == OFS_C1 |=> (rdata & 16'h0401) == (mir_r[OFS_C1] & 16'h0401);
   endproperty
   a_c1: assert property (p_c1) else $error("control one");
   property p_qc;
      rd && addr == OFS_QC |=> (rdata & QC_WMASK) == (mir_r[OFS_QC] & QC_WMASK);
   endproperty
   a_qc: assert property (p_qc) else $error("queue control");
   property p_dbt; rd && addr == OFS_DBT |=> rdata == mir_r[OFS_DBT]; endproperty
   a_dbt: assert property (p_dbt) else $error("byte threshold");
   property p_fc;
      rd && addr == OFS_FC |=> rdata[7:0] == mir_r[OFS_FC][7:0];
   endproperty
   a_fc: assert property (p_fc) else $error("frame threshold");
   property p_dp;
      rd && addr == OFS_DP |=> rdata[DP_AINC] == mir_r[OFS_DP][DP_AINC];
   endproperty
   a_dp: assert property (p_dp) else $error("pointer mode");
endmodule

// [dv/rx_queue_host_readout_tb.sv]
// bench: host end and device end joined by the register bus
// assumes software reaches the device only through axi4-lite
`timescale 1ns/10ps
module rx_queue_host_readout_tb
   import rqh_pkg::*;
;
   // ---------------------------------------------
   // ends, bus and bus tasks
   // ---------------------------------------------
   logic aclk = 1'b0, aresetn = 1'b0, rx_valid = 1'b0;
   logic [15:0] rx_data = 16'h0000, last;
   logic rx_ready, flow_pause, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, s_axi_wdata = 32'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] bres;
   int failures = 0, checks = 0;
   always #5 aclk = ~aclk;
   rqh_if rif (.aclk(aclk));
   rqh_device rqh_device_inst (.*, .bus(rif));
   rqh_host rqh_host_inst (.*, .bus(rif));
   rqh_monitor rqh_monitor_inst (.aclk, .aresetn, .addr(rif.addr),
      .wdata(rif.wdata), .wr(rif.wr), .rd(rif.rd), .rdata(rif.rdata),
      .ack(rif.ack), .irq(rif.irq));
   task automatic print_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic tmo();
      failures++;
      $display("MISMATCH %0t wait ran out", $time);
      print_verdict();
   endtask
   task automatic till(ref logic s);
      int n;
      for (n = 0; n < 300; n++) begin
         @(negedge aclk);
         if (s === 1'b1) break;
      end
      if (n == 300) tmo();
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw;
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 99; n++) begin
         @(negedge aclk);
         if (!s_axi_awvalid && !s_axi_wvalid) break;
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (ta || tw) s_axi_bready <= 1'b1;
      end
      if (n == 99) tmo();
      till(s_axi_bvalid);
      bres = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      till(s_axi_arready);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      till(s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask
   // one device access: command, then poll busy so ops never overlap
   task automatic dev(input logic [1:0] op, input logic [7:0] a,
         input logic [15:0] v);
      logic [31:0] x;
      logic [1:0] r;
      int n;
      axi_wr(H_CMD, {v, 6'h00, op, a});
      for (n = 0; n < 50; n++) begin
         axi_rd(H_STAT, x, r);
         if (x[0] === 1'b0) break;
      end
      if (n == 50) tmo();
      last = x[31:16];
   endtask
   // one frame-read word: wait until one is waiting, then take it
   task automatic pop();
      logic [31:0] x;
      logic [1:0] r;
      int n;
      for (n = 0; n < 50; n++) begin
         axi_rd(H_STAT, x, r);
         if (x[1] === 1'b1) break;
      end
      if (n == 50) tmo();
      axi_rd(H_DATA, x, r);
      last = x[15:0];
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] m, e);
      dev(OP_RD, a, 16'h0000);
      chk(last & m, e);
   endtask
   task automatic push(input logic [15:0] w);
      rx_valid <= 1'b1;
      rx_data <= w;
      till(rx_ready);
      @(posedge aclk);
   endtask
   task automatic send(input logic [15:0] st, cnt);
      push(st);
      push(cnt);
      for (int i = 0; i < (cnt + 1) / 2; i++) push(16'(i) * 16'h0202 + 16'h0100);
      rx_valid <= 1'b0;
   endtask
   task automatic t_regs();
      logic [31:0] x;
      logic [1:0] r;
      dev(OP_WR, OFS_C1, 16'h0401);
      rdc(OFS_C1, 16'h0401, 16'h0401);
      dev(OP_WR, OFS_DBT, 16'hffff);
      rdc(OFS_DBT, 16'hffff, 16'hffff);
      dev(OP_WR, OFS_HSR, 16'h1234);
      rdc(OFS_HSR, 16'hffff, 16'h0000);
      rdc(8'h00, 16'hffff, 16'h0000);
      axi_rd(8'h0c, x, r);
      chk({14'h0, r}, {14'h0, RESP_ERR});
   endtask
   task automatic t_frames();
      dev(OP_WR, OFS_FC, 16'h0001);
      dev(OP_WR, OFS_IER, 16'h2000);
      dev(OP_WR, OFS_QC, 16'h0020);
      send(16'h8001, 16'h0005);
      rdc(OFS_QC, 16'h0420, 16'h0020);
      send(16'h8002, 16'h0006);
      rdc(OFS_QC, 16'h0420, 16'h0420);
      rdc(OFS_ISR, 16'h2000, 16'h2000);
      chk({15'h0000, rif.irq}, 16'h0001);
      dev(OP_WR, OFS_IER, 16'h0000);
      chk({15'h0000, rif.irq}, 16'h0000);
      dev(OP_WR, OFS_IER, 16'h2000);
      dev(OP_WR, OFS_ISR, 16'hffff);
      chk({15'h0000, rif.irq}, 16'h0000);
      rdc(OFS_FC, 16'hffff, 16'h0201);
      rdc(OFS_HSR, 16'hffff, 16'h8001);
      rdc(OFS_HBC, 16'h0fff, 16'h0005);
      rdc(OFS_HSR, 16'hffff, 16'h8002);
      rdc(OFS_HBC, 16'h0fff, 16'h0006);
   endtask
   task automatic t_window();
      dev(OP_WR, OFS_DP, 16'h4000);
      dev(OP_WR, OFS_QC, 16'h0018);
      rdc(OFS_DP, 16'h4000, 16'h4000);
      rdc(OFS_DATA, 16'hffff, 16'h0000);
      rdc(OFS_DATA, 16'hffff, 16'h8001);
      rdc(OFS_DATA, 16'h0fff, 16'h0005);
      rdc(OFS_DATA, 16'hffff, 16'h0100);
      // read on to the double-word end
      repeat (3) dev(OP_RD, OFS_DATA, 16'h0000);
      dev(OP_WR, OFS_QC, 16'h0010);
      dev(OP_WR, OFS_DP, 16'h4000);
      dev(OP_WR, OFS_QC, 16'h0018);
      dev(OP_RD, OFS_DATA, 16'h0000);
      rdc(OFS_DATA, 16'hffff, 16'h8002);
   endtask
   task automatic t_stream();
      logic [31:0] x;
      logic [1:0] r;
      dev(OP_WR, OFS_QC, 16'h0010);
      dev(OP_WR, OFS_DBT, 16'h0004);
      dev(OP_WR, OFS_DTT, 16'h0002);
      dev(OP_WR, OFS_QC, 16'h00c0);
      rdc(OFS_QC, 16'h1800, 16'h0000);
      chk({15'h0000, flow_pause}, 16'h0000);
      send(16'h8003, 16'h0050);
      repeat (400) @(posedge aclk);
      rdc(OFS_QC, 16'h1800, 16'h1800);
      chk({15'h0000, flow_pause}, 16'h0001);
      axi_wr(H_STAT, 32'h0000_0000);
      chk({14'h0, bres}, {14'h0, RESP_ERR});
      dev(OP_WR, OFS_QC, 16'h00c8);
      axi_wr(H_CMD, {16'h0050, 6'h00, OP_FRM, 8'h00});
      chk({14'h0, bres}, {14'h0, RESP_OK});
      pop();
      chk(last, 16'h8003);
      pop();
      chk(last, 16'h0050);
      repeat (38) pop();
      chk(last, 16'h4b4a);
      axi_rd(H_STAT, x, r);
      chk(x[15:0] & 16'h0003, 16'h0000);
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_frames();
      t_window();
      t_stream();
      print_verdict();
   end
endmodule

// [verilog/rqh_device.sv]
// receive queue with its host-visible control and header readout
// assumes frames arrive as 16-bit words: status, byte count, data
`timescale 1ns/10ps
module rqh_device
   import rqh_pkg::*;
#(
   parameter int DEPTH = 2048
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   rqh_if.dev bus,
   // frame source
   input wire logic rx_valid,
   input wire logic [15:0] rx_data,
   output logic rx_ready,
   // flow control request
   output logic flow_pause
);
   localparam int AW = $clog2(DEPTH);
   // refused at elaboration: smaller queues cannot hold two frames
   if (DEPTH < 2 * MAX_FRM_WORDS || (1 << AW) != DEPTH) begin : g_depth
      $error("DEPTH must be a power of two of two frames or more");
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [AW-1:0] fsz(input logic [11:0] bc);
      fsz = AW'(2 + ((32'(bc) + 3) >> 2) * 2);
   endfunction
   function automatic logic hit(input logic [7:0] ofs);
      hit = bus.addr == ofs;
   endfunction

   typedef enum {ST_STAT, ST_CNT, ST_OFF, ST_DATA, ST_PAD} rqh_wst_type;
   logic [15:0] mem [DEPTH];
   rqh_wst_type wst_r, wst_nxt;
   logic [AW-1:0] wp_r, wp_nxt, head_r, head_nxt, hdr_r, hdr_nxt;
   logic [AW-1:0] rp_r, rp_nxt;
   logic [11:0] left_r, left_nxt, bc_r, bc_nxt;
   logic pad_r, pad_nxt, dummy_r, dummy_nxt, hload_r, hload_nxt;
   logic [1:0] hrd_r, hrd_nxt;
   logic [15:0] c1_r, c1_nxt, c2_r, c2_nxt, qc_r, qc_nxt, ain_r, ain_nxt;
   logic [15:0] dtt_r, dtt_nxt, dbt_r, dbt_nxt, ier_r, ier_nxt;
   logic [15:0] isr_r, isr_nxt, hsr_r, hsr_nxt, nby_r, nby_nxt;
   logic [15:0] dur_r, dur_nxt, rdata_r, rdata_nxt, nfr_r, nfr_nxt;
   logic [11:0] hbc_r, hbc_nxt;
   logic [7:0] fth_r, fth_nxt, fsn_r, fsn_nxt;
   logic [7:0] usd_r, usd_nxt;
   logic [2:0] thr_r, thr_nxt;
   logic ack_r, ack_nxt;
   logic mem_we, take, commit, deq, fcs, bcs, dts;
   logic [15:0] mem_wd, rd_val, qc_rd;
   logic [AW-1:0] used;
   logic [11:0] head_bc, bcx;

   assign used = wp_r - head_r;
   assign head_bc = mem[head_r + AW'(1)][11:0];
   assign fcs = qc_r[QC_FCE] && nfr_r > {8'h00, fth_r};
   assign bcs = qc_r[QC_BCE] && nby_r > dbt_r;
   assign dts = qc_r[QC_DTE] && dur_r > dtt_r;
   assign qc_rd = qc_r | {3'b000, dts, bcs, fcs, 10'h000};

   // ------------------------------------------------------------
   // frame write path
   // ------------------------------------------------------------
   always_comb begin
      wst_nxt = wst_r;
      wp_nxt = wp_r;
      left_nxt = left_r;
      bc_nxt = bc_r;
      pad_nxt = pad_r;
      mem_we = 1'b0;
      mem_wd = rx_data;
      commit = 1'b0;
      rx_ready = 1'b0;
      bcx = rx_data[11:0];
      if (qc_r[QC_OFS]) begin
         bcx = rx_data[11:0] + 12'h002;
      end
      unique case (wst_r)
         ST_STAT: begin
            // block enable, room for largest frame
            rx_ready = c1_r[C1_EN] && (DEPTH - 32'(used)) > MAX_FRM_WORDS;
         end
         ST_CNT, ST_DATA: rx_ready = 1'b1;
         ST_OFF, ST_PAD: rx_ready = 1'b0;
      endcase
      take = rx_valid && rx_ready;
      unique case (wst_r)
         ST_STAT: begin
            if (take) begin
               wst_nxt = ST_CNT;
            end
         end
         ST_CNT: begin
            if (take) begin
               mem_wd = {4'h0, bcx};
               bc_nxt = bcx;
               left_nxt = 12'((32'(bcx) + 1) >> 1);
               pad_nxt = ~left_nxt[0];
               wst_nxt = qc_r[QC_OFS] ? ST_OFF : ST_DATA;
            end
         end
         ST_OFF: begin
            mem_we = 1'b1;
            mem_wd = 16'h0000;
            wp_nxt = wp_r + AW'(1);
            left_nxt = left_r - 12'h001;
            wst_nxt = ST_DATA;
         end
         ST_DATA: begin
            if (take) begin
               left_nxt = left_r - 12'h001;
               if (left_r == 12'h001) begin
                  wst_nxt = ST_PAD;
               end
            end
         end
         ST_PAD: begin
            mem_we = ~pad_r;
            mem_wd = 16'h0000;
            wp_nxt = pad_r ? wp_r : wp_r + AW'(1);
            commit = 1'b1;
            wst_nxt = ST_STAT;
         end
      endcase
      if (take) begin
         mem_we = 1'b1;
         wp_nxt = wp_r + AW'(1);
      end
   end

   // ------------------------------------------------------------
   // register file, queue accounting, readout
   // ------------------------------------------------------------
   always_comb begin
      unique case (1'b1)
         hit(OFS_C1): rd_val = c1_r;
         hit(OFS_C2): rd_val = c2_r;
         hit(OFS_HSR): rd_val = hsr_r;
         hit(OFS_HBC): rd_val = {4'h0, hbc_r};
         hit(OFS_QC): rd_val = qc_rd;
         hit(OFS_DP): rd_val = ain_r | 16'(rp_r - head_r);
         hit(OFS_DTT): rd_val = dtt_r;
         hit(OFS_DBT): rd_val = dbt_r;
         hit(OFS_IER): rd_val = ier_r;
         hit(OFS_ISR): rd_val = isr_r;
         hit(OFS_FC): rd_val = {fsn_r, fth_r};
         hit(OFS_DATA): rd_val = dummy_r ? 16'h0000 : mem[rp_r];
         default: rd_val = 16'h0000;
      endcase
   end

   always_comb begin
      c1_nxt = c1_r;
      c2_nxt = c2_r;
      qc_nxt = qc_r;
      ain_nxt = ain_r;
      dtt_nxt = dtt_r;
      dbt_nxt = dbt_r;
      ier_nxt = ier_r;
      fth_nxt = fth_r;
      fsn_nxt = fsn_r;
      isr_nxt = isr_r;
      rp_nxt = rp_r;
      dummy_nxt = dummy_r;
      head_nxt = head_r;
      hdr_nxt = hdr_r;
      hload_nxt = 1'b0;
      hrd_nxt = hrd_r;
      hsr_nxt = hsr_r;
      hbc_nxt = hbc_r;
      deq = 1'b0;
      rdata_nxt = rdata_r;
      ack_nxt = bus.wr || bus.rd;
      thr_nxt = {dts, bcs, fcs};
      if (bus.rd) begin
         rdata_nxt = rd_val;
      end
      if (bus.wr) begin
         if (hit(OFS_C1)) c1_nxt = bus.wdata;
         if (hit(OFS_C2)) c2_nxt = bus.wdata;
         if (hit(OFS_DTT)) dtt_nxt = bus.wdata;
         if (hit(OFS_DBT)) dbt_nxt = bus.wdata;
         if (hit(OFS_IER)) ier_nxt = bus.wdata;
         if (hit(OFS_FC)) fth_nxt = bus.wdata[7:0];
         if (hit(OFS_DP)) begin
            ain_nxt = bus.wdata & 16'h4000;
            rp_nxt = head_r + bus.wdata[AW-1:0];
         end
         if (hit(OFS_ISR)) begin
            isr_nxt = isr_r & ~bus.wdata;
            if (bus.wdata[IS_RX] && isr_r[IS_RX]) begin
               fsn_nxt = nfr_r > 16'h00ff ? 8'hff : nfr_r[7:0];
            end
         end
         if (hit(OFS_QC)) begin
            qc_nxt = bus.wdata & QC_WMASK;
            if (bus.wdata[QC_DMA] && !qc_r[QC_DMA]) begin
               rp_nxt = head_r;
               dummy_nxt = 1'b1;
            end
            if (!bus.wdata[QC_DMA] && qc_r[QC_DMA] && qc_r[QC_ADQ]) begin
               deq = nfr_r != 16'h0000;
            end
         end
      end
      if (bus.rd && hit(OFS_DATA) && qc_r[QC_DMA]) begin
         dummy_nxt = 1'b0;
         if (!dummy_r && ain_r[DP_AINC]) begin
            rp_nxt = rp_r + AW'(1);
         end
      end
      if (bus.rd && hit(OFS_FC)) begin
         hdr_nxt = head_r;
         hload_nxt = 1'b1;
         hrd_nxt = 2'b00;
      end
      if (bus.rd && hit(OFS_HSR)) hrd_nxt[0] = 1'b1;
      if (bus.rd && hit(OFS_HBC)) hrd_nxt[1] = 1'b1;
      if (hrd_nxt == 2'b11) begin
         hdr_nxt = hdr_r + fsz(hbc_r);
         hload_nxt = 1'b1;
         hrd_nxt = 2'b00;
      end
      if (hload_r) begin
         hsr_nxt = mem[hdr_r];
         hbc_nxt = mem[hdr_r + AW'(1)][11:0];
      end
      if (deq) begin
         head_nxt = head_r + fsz(head_bc);
      end
      if (|({dts, bcs, fcs} & ~thr_r)) begin
         isr_nxt[IS_RX] = 1'b1;
      end
   end

   always_comb begin
      nfr_nxt = nfr_r + (commit ? 16'h0001 : 16'h0000)
         - (deq ? 16'h0001 : 16'h0000);
      nby_nxt = nby_r + (commit ? 16'(bc_r) : 16'h0000)
         - (deq ? 16'(head_bc) : 16'h0000);
      usd_nxt = usd_r + 8'h01;
      dur_nxt = dur_r;
      if (32'(usd_r) == US_CYC - 1) begin
         usd_nxt = 8'h00;
         if (dur_r != 16'hffff) dur_nxt = dur_r + 16'h0001;
      end
      // residence restarts with each head frame
      if (deq || nfr_r == 16'h0000) begin
         dur_nxt = 16'h0000;
      end
   end

   assign flow_pause = c1_r[C1_FLOW]
      && (DEPTH - 32'(used)) < 2 * MAX_FRM_WORDS;
   assign bus.irq = |(isr_r & ier_r & 16'h2000);
   assign bus.rdata = rdata_r;
   assign bus.ack = ack_r;

   always_ff @(posedge aclk) begin
      if (mem_we) begin
         mem[wp_r] <= mem_wd;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wst_r <= ST_STAT;
         wp_r <= '0;
         head_r <= '0;
         hdr_r <= '0;
         rp_r <= '0;
         left_r <= 12'h000;
         bc_r <= 12'h000;
         pad_r <= 1'b0;
         dummy_r <= 1'b0;
         hload_r <= 1'b0;
         hrd_r <= 2'b00;
         c1_r <= RST_REG;
         c2_r <= RST_REG;
         qc_r <= RST_REG;
         ain_r <= RST_REG;
         dtt_r <= RST_REG;
         dbt_r <= RST_REG;
         ier_r <= RST_REG;
         isr_r <= RST_REG;
         hsr_r <= RST_REG;
         hbc_r <= 12'h000;
         nby_r <= RST_REG;
         nfr_r <= RST_REG;
         dur_r <= RST_REG;
         rdata_r <= RST_REG;
         fth_r <= 8'h00;
         fsn_r <= 8'h00;
         usd_r <= 8'h00;
         thr_r <= 3'b000;
         ack_r <= 1'b0;
      end else begin
         wst_r <= wst_nxt;
         wp_r <= wp_nxt;
         head_r <= head_nxt;
         hdr_r <= hdr_nxt;
         rp_r <= rp_nxt;
         left_r <= left_nxt;
         bc_r <= bc_nxt;
         pad_r <= pad_nxt;
         dummy_r <= dummy_nxt;
         hload_r <= hload_nxt;
         hrd_r <= hrd_nxt;
         c1_r <= c1_nxt;
         c2_r <= c2_nxt;
         qc_r <= qc_nxt;
         ain_r <= ain_nxt;
         dtt_r <= dtt_nxt;
         dbt_r <= dbt_nxt;
         ier_r <= ier_nxt;
         isr_r <= isr_nxt;
         hsr_r <= hsr_nxt;
         hbc_r <= hbc_nxt;
         nby_r <= nby_nxt;
         nfr_r <= nfr_nxt;
         dur_r <= dur_nxt;
         rdata_r <= rdata_nxt;
         fth_r <= fth_nxt;
         fsn_r <= fsn_nxt;
         usd_r <= usd_nxt;
         thr_r <= thr_nxt;
         ack_r <= ack_nxt;
      end
   end
endmodule

// [verilog/rqh_host.sv]
// host end: axi4-lite command registers drive the register bus
// assumes software handles interrupt service and window control
`timescale 1ns/10ps
module rqh_host
   import rqh_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // register bus
   rqh_if.hst bus
);
   typedef enum {HS_IDLE, HS_ISSUE, HS_WAIT, HS_HOLD} rqh_hst_type;
   rqh_hst_type st_r, st_nxt;
   logic [7:0] awa_r, awa_nxt, addr_r, addr_nxt;
   logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
   logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
   logic [1:0] br_r, br_nxt, rr_r, rr_nxt, op_r, op_nxt;
   logic [15:0] wdat_r, wdat_nxt, last_r, last_nxt, hold_r, hold_nxt;
   logic [11:0] left_r, left_nxt;
   logic dum_r, dum_nxt, pop;

   assign s_axi_awready = !aw_r && !bv_r;
   assign s_axi_wready = !w_r && !bv_r;
   assign s_axi_arready = !rv_r;
   assign s_axi_bvalid = bv_r;
   assign s_axi_bresp = br_r;
   assign s_axi_rvalid = rv_r;
   assign s_axi_rresp = rr_r;
   assign s_axi_rdata = rd_r;
   assign bus.addr = addr_r;
   assign bus.wdata = wdat_r;
   assign bus.wr = st_r == HS_ISSUE && op_r == OP_WR;
   assign bus.rd = st_r == HS_ISSUE && op_r != OP_WR;

   always_comb begin
      st_nxt = st_r;
      awa_nxt = awa_r;
      aw_nxt = aw_r;
      w_nxt = w_r;
      wd_nxt = wd_r;
      bv_nxt = bv_r && !s_axi_bready;
      br_nxt = br_r;
      rv_nxt = rv_r && !s_axi_rready;
      rd_nxt = rd_r;
      rr_nxt = rr_r;
      addr_nxt = addr_r;
      op_nxt = op_r;
      wdat_nxt = wdat_r;
      last_nxt = last_r;
      hold_nxt = hold_r;
      left_nxt = left_r;
      dum_nxt = dum_r;
      pop = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_nxt = 1'b1;
         awa_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_nxt = 1'b1;
         wd_nxt = s_axi_wdata;
      end
      // command taken once address and data are both held
      if (aw_r && w_r) begin
         aw_nxt = 1'b0;
         w_nxt = 1'b0;
         bv_nxt = 1'b1;
         br_nxt = RESP_ERR;
         if (awa_r == H_CMD && st_r == HS_IDLE && wd_r[9:8] != 2'h3) begin
            br_nxt = RESP_OK;
            op_nxt = wd_r[9:8];
            addr_nxt = wd_r[7:0];
            wdat_nxt = wd_r[31:16];
            st_nxt = HS_ISSUE;
            if (wd_r[9:8] == OP_FRM) begin
               // dummy word, then whole double words
               addr_nxt = OFS_DATA;
               dum_nxt = 1'b1;
               left_nxt = 12'(((32'(wd_r[27:16]) + 3) >> 2) * 2);
               st_nxt = wd_r[27:16] == 12'h000 ? HS_IDLE : HS_ISSUE;
            end
         end
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rv_nxt = 1'b1;
         rr_nxt = RESP_OK;
         unique case (s_axi_araddr)
            H_STAT: rd_nxt = {last_r, 13'h0000, bus.irq,
               st_r == HS_HOLD, st_r != HS_IDLE};
            H_DATA: begin
               rd_nxt = {16'h0000, hold_r};
               pop = st_r == HS_HOLD;
            end
            H_CMD: rd_nxt = {wdat_r, 6'h00, op_r, addr_r};
            default: begin
               rd_nxt = 32'h0000_0000;
               rr_nxt = RESP_ERR;
            end
         endcase
      end
      unique case (st_r)
         HS_IDLE: ;
         HS_ISSUE: st_nxt = HS_WAIT;
         HS_WAIT: begin
            if (bus.ack) begin
               st_nxt = HS_IDLE;
               if (op_r == OP_RD) last_nxt = bus.rdata;
               if (op_r == OP_FRM) begin
                  if (dum_r) begin
                     dum_nxt = 1'b0;
                     st_nxt = HS_ISSUE;
                  end else begin
                     hold_nxt = bus.rdata;
                     left_nxt = left_r - 12'h001;
                     st_nxt = HS_HOLD;
                  end
               end
            end
         end
         HS_HOLD: begin
            if (pop) st_nxt = left_r == 12'h000 ? HS_IDLE : HS_ISSUE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= HS_IDLE;
         awa_r <= 8'h00;
         aw_r <= 1'b0;
         w_r <= 1'b0;
         wd_r <= 32'h0000_0000;
         bv_r <= 1'b0;
         br_r <= RESP_OK;
         rv_r <= 1'b0;
         rd_r <= 32'h0000_0000;
         rr_r <= RESP_OK;
         addr_r <= 8'h00;
         op_r <= OP_WR;
         wdat_r <= 16'h0000;
         last_r <= 16'h0000;
         hold_r <= 16'h0000;
         left_r <= 12'h000;
         dum_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         awa_r <= awa_nxt;
         aw_r <= aw_nxt;
         w_r <= w_nxt;
         wd_r <= wd_nxt;
         bv_r <= bv_nxt;
         br_r <= br_nxt;
         rv_r <= rv_nxt;
         rd_r <= rd_nxt;
         rr_r <= rr_nxt;
         addr_r <= addr_nxt;
         op_r <= op_nxt;
         wdat_r <= wdat_nxt;
         last_r <= last_nxt;
         hold_r <= hold_nxt;
         left_r <= left_nxt;
         dum_r <= dum_nxt;
      end
   end
endmodule
